/* File: verilog/ufs_pkg.sv */
// Shared constants for the USB port fault supervisor.
package ufs_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 10;
  localparam int NS_PER_MS      = 1_000_000;
  localparam int DEGLITCH_MS    = 8;
  localparam int HICCUP_OFF_MS  = 118;
  // Least time rounds up to whole cycles.
  localparam int DEGLITCH_CYCLES = (DEGLITCH_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longest time rounds down to whole cycles.
  localparam int HICCUP_OFF_CYCLES = (HICCUP_OFF_MS * NS_PER_MS) / CLK_PERIOD_NS;
  localparam int SHORT_CYCLE_COUNT = 128;
  localparam int SOFT_START_CYCLES = 1024;

  // ****************************************************************
  // Synchroniser bit positions of the comparator, switching clock and limit select inputs
  // ****************************************************************
  localparam int IDX_DP     = 0;
  localparam int IDX_DM     = 1;
  localparam int IDX_CC1    = 2;
  localparam int IDX_CC2    = 3;
  localparam int IDX_BUS    = 4;
  localparam int IDX_SHORT  = 5;
  localparam int IDX_SWCLK  = 6;
  localparam int IDX_OVLD   = 7;
  localparam int IDX_EXTFET = 8;
  localparam int SYNC_W     = 9;

  // ****************************************************************
  // Deglitched overvoltage sources
  // ****************************************************************
  localparam int SRC_BUS  = 0;
  localparam int SRC_DATA = 1;
  localparam int SRC_CFG  = 2;
  localparam int SRC_N    = 3;

  // Regulator hiccup states.
  typedef enum logic [1:0] {
    UFS_SOFT,
    UFS_RUN,
    UFS_OFF
  } ufs_hic_t;

endpackage

/* File: verilog/ufs_dgl_if.sv */
// Interface joining one fault condition to its deglitch filter.
`timescale 1ns/1ns
interface ufs_dgl_if;
  logic cond;
  logic filt;
  modport src (output cond, input filt);
  modport flt (input cond, output filt);
endinterface

/* File: verilog/ufs_deglitch.sv */
// Symmetric deglitch filter for one fault condition.
`timescale 1ns/1ns
module ufs_deglitch #(
  parameter int CYCLES = ufs_pkg::DEGLITCH_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic rstn,
  ufs_dgl_if.flt    link
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt;

  // ****************************************************************
  // Filter
  // ****************************************************************
  // The filtered level follows only after the condition has differed from it for the full interval.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt       <= '0;
      link.filt <= 1'h0;
    end else if (link.cond == link.filt) begin
      cnt <= '0;
    end else if (cnt == LAST) begin
      cnt       <= '0;
      link.filt <= link.cond;
    end else begin
      cnt <= cnt + CW'(1);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_filter_change: assert property (@(posedge sys_clk) disable iff (!rstn)
    (link.filt != $past(link.filt)) |-> ($past(cnt) == LAST && $past(link.cond) == link.filt))
    else $error("Deglitch output changed before the full interval.");

endmodule // ufs_deglitch

/* File: verilog/ufs_fault_supervisor.sv */
// Protection and fault supervisor of a USB charging port.
`timescale 1ns/1ns

module ufs_fault_supervisor #(
  parameter int DEGLITCH_CYCLES   = ufs_pkg::DEGLITCH_CYCLES,
  parameter int HICCUP_OFF_CYCLES = ufs_pkg::HICCUP_OFF_CYCLES,
  parameter int SOFT_START_CYCLES = ufs_pkg::SOFT_START_CYCLES,
  parameter int SHORT_CYCLE_COUNT = ufs_pkg::SHORT_CYCLE_COUNT
) (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic dataPlusOvCmp,
  input  wire logic dataMinusOvCmp,
  input  wire logic cfg1OvCmp,
  input  wire logic cfg2OvCmp,
  input  wire logic busOvCmp,
  input  wire logic outputShortCmp,
  input  wire logic switchingClock,
  input  wire logic overloadCmp,
  input  wire logic limitByExtFet,
  output logic      dataPlusSwitchOn,
  output logic      dataMinusSwitchOn,
  output logic      dataPlusDischarge,
  output logic      dataMinusDischarge,
  output logic      cfg1SwitchOn,
  output logic      cfg2SwitchOn,
  output logic      cfg1Discharge,
  output logic      cfg2Discharge,
  output logic      busDischarge,
  output logic      loadSwitchGateDrive,
  output logic      extFetLimit,
  output logic      buckCurrentLimit,
  output logic      regulatorEnable,
  output logic      softStart,
  output logic      faultOut,
  output logic      faultOe
);

  localparam int HW = $clog2(HICCUP_OFF_CYCLES + 1);
  localparam int SW = $clog2(SOFT_START_CYCLES + 1);
  localparam int NW = $clog2(SHORT_CYCLE_COUNT + 1);
  localparam logic [HW-1:0] HIC_LAST   = HW'(HICCUP_OFF_CYCLES - 1);
  localparam logic [SW-1:0] SOFT_LAST  = SW'(SOFT_START_CYCLES - 1);
  localparam logic [NW-1:0] SHORT_LAST = NW'(SHORT_CYCLE_COUNT - 1);

  logic [ufs_pkg::SYNC_W-1:0] syncA;
  logic [ufs_pkg::SYNC_W-1:0] syncB;
  logic                       swClkPrev;
  logic                       swTick;
  logic                       dataOv;
  logic                       cfgOv;
  logic [ufs_pkg::SRC_N-1:0]  ovCond;
  logic [ufs_pkg::SRC_N-1:0]  ovFilt;
  ufs_pkg::ufs_hic_t          hicState;
  logic [NW-1:0]              shortCnt;
  logic [HW-1:0]              hicTimer;
  logic [SW-1:0]              softTimer;
  logic                       hicOff;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // All comparator inputs are asynchronous and pass two flip-flops; the switching clock is edge detected after them.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      syncA     <= '0;
      syncB     <= '0;
      swClkPrev <= 1'h0;
    end else begin
      syncA     <= {limitByExtFet, overloadCmp, switchingClock, outputShortCmp,
                    busOvCmp, cfg2OvCmp, cfg1OvCmp, dataMinusOvCmp, dataPlusOvCmp};
      syncB     <= syncA;
      swClkPrev <= syncB[ufs_pkg::IDX_SWCLK];
    end
  end

  // Condition decode.
  assign swTick = syncB[ufs_pkg::IDX_SWCLK] && !swClkPrev;
  assign dataOv = syncB[ufs_pkg::IDX_DP] || syncB[ufs_pkg::IDX_DM];
  assign cfgOv  = syncB[ufs_pkg::IDX_CC1] || syncB[ufs_pkg::IDX_CC2];
  assign hicOff = (hicState == ufs_pkg::UFS_OFF);
  assign ovCond[ufs_pkg::SRC_BUS]  = syncB[ufs_pkg::IDX_BUS];
  assign ovCond[ufs_pkg::SRC_DATA] = dataOv;
  assign ovCond[ufs_pkg::SRC_CFG]  = cfgOv;

  // ****************************************************************
  // Protective switch actions
  // ****************************************************************
  // Switches and discharge paths react without deglitch and recover by themselves.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dataPlusSwitchOn    <= 1'h1;
      dataMinusSwitchOn   <= 1'h1;
      dataPlusDischarge   <= 1'h0;
      dataMinusDischarge  <= 1'h0;
      cfg1SwitchOn        <= 1'h1;
      cfg2SwitchOn        <= 1'h1;
      cfg1Discharge       <= 1'h0;
      cfg2Discharge       <= 1'h0;
      busDischarge        <= 1'h0;
      loadSwitchGateDrive <= 1'h0;
    end else begin
      dataPlusSwitchOn    <= !dataOv;
      dataMinusSwitchOn   <= !dataOv;
      dataPlusDischarge   <= syncB[ufs_pkg::IDX_DP];
      dataMinusDischarge  <= syncB[ufs_pkg::IDX_DM];
      cfg1SwitchOn        <= !cfgOv;
      cfg2SwitchOn        <= !cfgOv;
      cfg1Discharge       <= syncB[ufs_pkg::IDX_CC1];
      cfg2Discharge       <= syncB[ufs_pkg::IDX_CC2];
      busDischarge        <= syncB[ufs_pkg::IDX_BUS];
      loadSwitchGateDrive <= !syncB[ufs_pkg::IDX_BUS] && !hicOff;
    end
  end

  // ****************************************************************
  // Minor overload current limiting
  // ****************************************************************
  // The limit is taken by the external switch or the buck loop; it never reaches the fault output.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      extFetLimit      <= 1'h0;
      buckCurrentLimit <= 1'h0;
    end else begin
      extFetLimit      <= syncB[ufs_pkg::IDX_OVLD] && syncB[ufs_pkg::IDX_EXTFET];
      buckCurrentLimit <= syncB[ufs_pkg::IDX_OVLD] && !syncB[ufs_pkg::IDX_EXTFET];
    end
  end

  // ****************************************************************
  // Hiccup sequencer
  // ****************************************************************
  // Consecutive short switching cycles are counted; any good cycle restarts the count.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hicState  <= ufs_pkg::UFS_SOFT;
      shortCnt  <= '0;
      hicTimer  <= '0;
      softTimer <= '0;
    end else begin
      unique case (hicState)
        ufs_pkg::UFS_SOFT: begin
          shortCnt <= '0;
          if (softTimer == SOFT_LAST) begin
            softTimer <= '0;
            hicState  <= ufs_pkg::UFS_RUN;
          end else begin
            softTimer <= softTimer + SW'(1);
          end
        end
        ufs_pkg::UFS_RUN: begin
          if (swTick && syncB[ufs_pkg::IDX_SHORT]) begin
            if (shortCnt == SHORT_LAST) begin
              shortCnt <= '0;
              hicState <= ufs_pkg::UFS_OFF;
            end else begin
              shortCnt <= shortCnt + NW'(1);
            end
          end else if (swTick) begin
            shortCnt <= '0;
          end
        end
        ufs_pkg::UFS_OFF: begin
          if (hicTimer == HIC_LAST) begin
            hicTimer <= '0;
            hicState <= ufs_pkg::UFS_SOFT;
          end else begin
            hicTimer <= hicTimer + HW'(1);
          end
        end
      endcase
    end
  end

  // Regulator control outputs.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      regulatorEnable <= 1'h0;
      softStart       <= 1'h0;
    end else begin
      regulatorEnable <= !hicOff;
      softStart       <= (hicState == ufs_pkg::UFS_SOFT);
    end
  end

  // ****************************************************************
  // Fault reporting
  // ****************************************************************
  // One deglitch filter per overvoltage source.
  for (genvar g = 0; g < ufs_pkg::SRC_N; g++) begin : gDgl
    ufs_dgl_if link ();
    assign link.cond = ovCond[g];
    assign ovFilt[g] = link.filt;
    ufs_deglitch #(
      .CYCLES (DEGLITCH_CYCLES)
    ) uFilt (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .link    (link.flt)
    );
  end

  // The pin level is always low; the enable pulls it while any source is active.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      faultOut <= 1'h0;
      faultOe  <= 1'h0;
    end else begin
      faultOut <= 1'h0;
      faultOe  <= (|ovFilt) || hicOff;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_short_last;
    hicState == ufs_pkg::UFS_RUN && shortCnt == SHORT_LAST && swTick && syncB[ufs_pkg::IDX_SHORT];
  endsequence

  sequence s_off_fault;
    hicOff ##1 (faultOe && !regulatorEnable);
  endsequence

  a_data_open: assert property (@(posedge sys_clk) disable iff (!rstn)
    dataOv |=> (!dataPlusSwitchOn && !dataMinusSwitchOn))
    else $error("Data switches not opened on overvoltage.");

  a_data_reclose: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!dataOv && $past(dataOv)) |=> (dataPlusSwitchOn && !dataPlusDischarge && !dataMinusDischarge))
    else $error("Data path not restored after overvoltage.");

  a_cfg_open: assert property (@(posedge sys_clk) disable iff (!rstn)
    cfgOv |=> (!cfg1SwitchOn && !cfg2SwitchOn))
    else $error("Configuration lines not disconnected.");

  a_cfg_discharge: assert property (@(posedge sys_clk) disable iff (!rstn)
    ##1 (cfg1Discharge == $past(syncB[ufs_pkg::IDX_CC1]) && cfg2Discharge == $past(syncB[ufs_pkg::IDX_CC2])))
    else $error("Configuration discharge does not follow overvoltage.");

  a_fault_od: assert property (@(posedge sys_clk) disable iff (!rstn)
    !faultOut)
    else $error("Open-drain fault pin driven high.");

  a_overload_nofault: assert property (@(posedge sys_clk) disable iff (!rstn)
    (faultOe && !$past(hicOff)) |-> $past(|ovFilt))
    else $error("Fault asserted without a fault source.");

  a_hiccup_fault: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_short_last |=> s_off_fault)
    else $error("Hiccup did not assert the fault.");

  a_hiccup_off: assert property (@(posedge sys_clk) disable iff (!rstn)
    (hicOff && !$past(hicOff)) |-> $past(shortCnt) == SHORT_LAST)
    else $error("Hiccup entered before the short-cycle count.");

  a_bus_gate: assert property (@(posedge sys_clk) disable iff (!rstn)
    syncB[ufs_pkg::IDX_BUS] |=> (!loadSwitchGateDrive && busDischarge))
    else $error("Bus overvoltage did not drop the gate drive.");

  a_fault_or: assert property (@(posedge sys_clk) disable iff (!rstn)
    ##1 (faultOe == ($past(|ovFilt) || $past(hicOff))))
    else $error("Fault is not the OR of its sources.");

endmodule // ufs_fault_supervisor

/* File: tb/ufs_port_model.sv */
// Far-side model of the connector, harness and attached device as comparator levels.
`timescale 1ns/1ns
module ufs_port_model (
  input  wire logic [5:0] stress,
  input  wire logic       heavyLoad,
  output logic            dataPlusOvCmp,
  output logic            dataMinusOvCmp,
  output logic            cfg1OvCmp,
  output logic            cfg2OvCmp,
  output logic            busOvCmp,
  output logic            outputShortCmp,
  output logic            overloadCmp
);
  // Harness shorts reach the comparators at once, as an analog level would.
  assign dataPlusOvCmp  = stress[0];
  assign dataMinusOvCmp = stress[1];
  assign cfg1OvCmp      = stress[2];
  assign cfg2OvCmp      = stress[3];
  assign busOvCmp       = stress[4];
  assign outputShortCmp = stress[5];
  // A device drawing above the programmed limit trips the overload comparator.
  assign overloadCmp    = heavyLoad;
endmodule // ufs_port_model

/* File: tb/tb_usb_port_fault_supervisor.sv */
// Self-checking testbench of the USB port fault supervisor.
`timescale 1ns/1ns
`define CHK(got, exp, msg) begin nTests++; if ((got) !== (exp)) begin badCount++; $display("CHECK FAILED %0t: %s", $time, msg); end end
module tb_usb_port_fault_supervisor;
  localparam int DG  = 8;
  localparam int OFF = 20;
  logic sys_clk = 1'h0, rstn = 1'h0, heavyLoad = 1'h0, switchingClock = 1'h0, limitByExtFet = 1'h0, swRun = 1'h0;
  logic [5:0] stress = 6'h00;
  logic dpC, dmC, c1C, c2C, busC, shC, olC;
  logic dataPlusSwitchOn, dataMinusSwitchOn, dataPlusDischarge, dataMinusDischarge, cfg1SwitchOn, cfg2SwitchOn;
  logic cfg1Discharge, cfg2Discharge, busDischarge, loadSwitchGateDrive, extFetLimit, buckCurrentLimit;
  logic regulatorEnable, softStart, faultOut, faultOe;
  logic [9:0] prot;
  int badCount = 0, nTests = 0, cycles = 0;

  // ****************************************************************
  // Clock, partner and design
  // ****************************************************************
  // Free-running system clock of 100 MHz.
  always #5 sys_clk = ~sys_clk;
  // The buck switching clock toggles on every rising edge while enabled, one switching cycle per two system cycles.
  always @(posedge sys_clk) begin
    if (swRun) switchingClock <= ~switchingClock;
  end
  // Protective outputs gathered for one compare.
  assign prot = {dataPlusSwitchOn, dataMinusSwitchOn, dataPlusDischarge, dataMinusDischarge, cfg1SwitchOn,
                 cfg2SwitchOn, cfg1Discharge, cfg2Discharge, busDischarge, loadSwitchGateDrive};
  ufs_port_model port (.stress(stress), .heavyLoad(heavyLoad), .dataPlusOvCmp(dpC), .dataMinusOvCmp(dmC),
    .cfg1OvCmp(c1C), .cfg2OvCmp(c2C), .busOvCmp(busC), .outputShortCmp(shC), .overloadCmp(olC));
  ufs_fault_supervisor #(.DEGLITCH_CYCLES(DG), .HICCUP_OFF_CYCLES(OFF), .SOFT_START_CYCLES(4),
    .SHORT_CYCLE_COUNT(4)) dut (.sys_clk(sys_clk), .rstn(rstn), .dataPlusOvCmp(dpC), .dataMinusOvCmp(dmC),
    .cfg1OvCmp(c1C), .cfg2OvCmp(c2C), .busOvCmp(busC), .outputShortCmp(shC), .switchingClock(switchingClock),
    .overloadCmp(olC), .limitByExtFet(limitByExtFet), .dataPlusSwitchOn(dataPlusSwitchOn),
    .dataMinusSwitchOn(dataMinusSwitchOn), .dataPlusDischarge(dataPlusDischarge),
    .dataMinusDischarge(dataMinusDischarge), .cfg1SwitchOn(cfg1SwitchOn), .cfg2SwitchOn(cfg2SwitchOn),
    .cfg1Discharge(cfg1Discharge), .cfg2Discharge(cfg2Discharge), .busDischarge(busDischarge),
    .loadSwitchGateDrive(loadSwitchGateDrive), .extFetLimit(extFetLimit), .buckCurrentLimit(buckCurrentLimit),
    .regulatorEnable(regulatorEnable), .softStart(softStart), .faultOut(faultOut), .faultOe(faultOe));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Waits whole cycles and samples after the edge has settled.
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Applies a harness condition on a rising edge.
  task automatic setStress(input logic [5:0] v);
    @(posedge sys_clk);
    stress <= v;
  endtask
  // Waits for the fault pin state and checks the wait fell inside its window.
  task automatic waitOe(input logic exp, input int lo, input int hi);
    int k;
    k = 0;
    while (faultOe !== exp && k < hi) begin
      tick(1);
      k++;
    end
    `CHK(k >= lo && k <= hi && faultOe === exp, 1'h1, "fault pin timing")
  endtask
  // Expected protective outputs for a set of harness shorts.
  function automatic logic [9:0] protExp(input logic [5:0] v);
    return {~(v[0] | v[1]), ~(v[0] | v[1]), v[0], v[1], ~(v[2] | v[3]), ~(v[2] | v[3]), v[2], v[3], v[4], ~v[4]};
  endfunction

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Each overvoltage source alone: switch action at once, fault through the deglitch.
  task automatic tOvSources();
    logic [5:0] v;
    for (int i = 0; i < 5; i++) begin
      v = 6'h01 << i;
      setStress(v);
      tick(3);
      `CHK(prot, protExp(v), "protective outputs on overvoltage")
      `CHK(faultOe, 1'h0, "fault before deglitch")
      waitOe(1'h1, DG - 1, DG + 2);
      `CHK(faultOut, 1'h0, "open drain data")
      setStress(6'h00);
      tick(3);
      `CHK(prot, protExp(6'h00), "protective outputs after clearing")
      `CHK(faultOe, 1'h1, "fault held during release deglitch")
      waitOe(1'h0, DG - 1, DG + 2);
    end
  endtask
  // Short pulse and short gap are both filtered out.
  task automatic tGlitch();
    int bad;
    bad = 0;
    setStress(6'h10);
    tick(DG - 2);
    setStress(6'h00);
    repeat (DG + 6) begin
      tick(1);
      if (faultOe !== 1'h0) bad++;
    end
    `CHK(bad, 0, "short pulse reached fault pin")
    setStress(6'h08);
    tick(3);
    waitOe(1'h1, DG - 1, DG + 2);
    setStress(6'h00);
    tick(DG - 2);
    setStress(6'h08);
    repeat (DG + 6) begin
      tick(1);
      if (faultOe !== 1'h1) bad++;
    end
    `CHK(bad, 0, "short gap released fault pin")
    setStress(6'h00);
    tick(3);
    waitOe(1'h0, DG - 1, DG + 2);
  endtask
  // Two sources overlap; dropping one keeps the fault.
  task automatic tOrSources();
    setStress(6'h10);
    tick(3);
    waitOe(1'h1, DG - 1, DG + 2);
    setStress(6'h12);
    tick(DG + 6);
    setStress(6'h02);
    tick(DG + 8);
    `CHK(faultOe, 1'h1, "remaining source holds fault")
    setStress(6'h00);
    tick(3);
    waitOe(1'h0, DG - 1, DG + 2);
  endtask
  // Minor overload in both limit modes never raises the fault.
  task automatic tOverload();
    for (int m = 0; m < 2; m++) begin
      @(posedge sys_clk);
      limitByExtFet <= m[0];
      heavyLoad <= 1'h1;
      tick(3);
      `CHK({extFetLimit, buckCurrentLimit}, {m[0], ~m[0]}, "limit means")
      tick(DG + 6);
      `CHK(faultOe, 1'h0, "no fault on overload")
      @(posedge sys_clk);
      heavyLoad <= 1'h0;
      tick(3);
      `CHK({extFetLimit, buckCurrentLimit}, 2'h0, "limit released")
    end
  endtask
  // Hard short: hiccup off-time with fault, soft restart, repeat, recovery.
  task automatic tHiccup();
    @(posedge sys_clk);
    limitByExtFet <= 1'h0;
    swRun <= 1'h1;
    stress <= 6'h20;
    // Four short cycles of two system cycles each, two sync stages, edge detect, state and pin flops.
    waitOe(1'h1, 10, 12);
    `CHK({regulatorEnable, loadSwitchGateDrive}, 2'h0, "regulator off in hiccup")
    waitOe(1'h0, OFF - 1, OFF + 1);
    tick(1);
    `CHK({regulatorEnable, softStart}, 2'h3, "soft restart")
    // Rest of the soft start, then four short cycles again before the next off-time.
    waitOe(1'h1, 10, 12);
    setStress(6'h00);
    waitOe(1'h0, OFF - 2, OFF + 1);
    tick(60);
    `CHK({faultOe, regulatorEnable, softStart}, 3'h2, "recovered")
    @(posedge sys_clk);
    swRun <= 1'h0;
  endtask

  // ****************************************************************
  // Run control
  // ****************************************************************
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Cuts a hang short well beyond the expected run length.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 4000) begin
      badCount++;
      $display("CHECK FAILED %0t: run did not finish", $time);
      summarize();
    end
  end
  // Reset, then every scenario in turn.
  initial begin
    tick(19);
    `CHK({faultOe, faultOut, prot}, {2'h0, 10'h330}, "reset outputs")
    @(posedge sys_clk);
    rstn <= 1'h1;
    tick(3);
    `CHK({faultOe, faultOut, prot}, {2'h0, protExp(6'h00)}, "idle outputs")
    tOvSources();
    tGlitch();
    tOrSources();
    tOverload();
    tHiccup();
    summarize();
  end
endmodule // tb_usb_port_fault_supervisor
